// ===== hdl/ccfg_ctrl.sv
/*
  two-wire bus controller for the configuration target, ordered by apb.
  assumes an apb master on pclk; makes the serial clock by a divider.
*/
`timescale 1ns/1ps
`default_nettype none
module ccfg_ctrl #(
  parameter int QTR = ccfg_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // serial link
  ccfg_if.ctrl bus
);
  typedef enum logic [1:0] {
    K_IDLE = 2'b00,
    K_START = 2'b01,
    K_BIT = 2'b10,
    K_STOP = 2'b11
  } ccfg_kstate_e;
  typedef enum logic [2:0] {
    P_ADDRW = 3'b000,
    P_CMD = 3'b001,
    P_CNT = 3'b010,
    P_WDAT = 3'b011,
    P_ADDRR = 3'b100,
    P_RCNT = 3'b101,
    P_RDAT = 3'b110
  } ccfg_phase_e;

  ccfg_kstate_e ks;
  ccfg_phase_e ph;
  ccfg_pkg::ccfg_op_e op;
  logic [15:0] qcnt; // quarter-period divider
  logic [1:0] q; // quarter within a bit
  logic [3:0] bitn; // bit within a nine-bit slot
  logic [8:0] txsh, rxsh; // slot shift registers
  logic [6:0] idx; // single-access index
  logic [2:0] len; // block length minus one
  logic [2:0] bidx; // byte position in buffer
  logic busy, err, done;
  logic [7:0] rcount; // count byte returned by a block read
  logic [7:0] dbuf [8]; // data bytes
  logic sda_s1, sda_s2; // data line sync

  wire tick = qcnt == 16'(QTR - 1);
  wire apb_acc = psel && penable && pready;
  wire ctl_wr = apb_acc && pwrite && paddr == ccfg_pkg::OFF_CTRL && !busy;
  wire d0_wr = apb_acc && pwrite && paddr == ccfg_pkg::OFF_DATA0 && !busy;
  wire d1_wr = apb_acc && pwrite && paddr == ccfg_pkg::OFF_DATA1 && !busy;
  wire mapped = paddr == ccfg_pkg::OFF_CTRL || paddr == ccfg_pkg::OFF_STAT
    || paddr == ccfg_pkg::OFF_DATA0 || paddr == ccfg_pkg::OFF_DATA1;
  wire blk = !op[1];
  wire rdop = op[0];
  wire last = bidx == (blk ? len : 3'd0);
  wire slot_end = ks == K_BIT && tick && q == 2'd3 && bitn == 4'd8;
  wire nack = rxsh[0];
  wire [7:0] cmd = blk ? 8'h00 : {1'b1, idx};
  wire [7:0] tx_byte = ph == P_ADDRW ? {ccfg_pkg::TGT_ADDR, 1'b0}
    : ph == P_ADDRR ? {ccfg_pkg::TGT_ADDR, 1'b1}
    : ph == P_CMD ? cmd
    : ph == P_CNT ? {5'd0, len} + 8'd1
    : ph == P_WDAT ? dbuf[bidx] : 8'hFF;
  // reads ack every byte but the last, which is nacked
  wire ack_bit = ph == P_RDAT && last;
  wire [8:0] slot = (ph == P_RCNT || ph == P_RDAT) ? {8'hFF, ack_bit} : {tx_byte, 1'b1};
  wire [7:0] rdsel = paddr == ccfg_pkg::OFF_STAT ? {5'd0, done, err, busy}
    : paddr == ccfg_pkg::OFF_CTRL ? {6'd0, op} : 8'h00;

  assign bus.scl_o = 1'b0;
  assign bus.sda_ctl_o = 1'b0;

  // apb: one wait state; write acts at the edge that sees pready high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
      if (psel && penable && !pready) begin
        prdata <= paddr == ccfg_pkg::OFF_DATA0 ? {dbuf[3], dbuf[2], dbuf[1], dbuf[0]}
          : paddr == ccfg_pkg::OFF_DATA1 ? {dbuf[7], dbuf[6], dbuf[5], dbuf[4]}
          : {16'h0000, paddr == ccfg_pkg::OFF_STAT ? rcount : 8'h00, rdsel};
      end
    end
  end

  // data line sync and quarter divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {sda_s1, sda_s2} <= 2'b11;
      qcnt <= 16'd0;
    end else begin
      sda_s1 <= bus.serial_bus_data_pin;
      sda_s2 <= sda_s1;
      qcnt <= (tick || !busy) ? 16'd0 : qcnt + 16'd1;
    end
  end

  // data buffer: apb writes while idle, engine stores read bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        dbuf[i] <= 8'h00;
      end
    end else if (slot_end && ph == P_RDAT) begin
      dbuf[bidx] <= rxsh[8:1];
    end else if (d0_wr) begin
      {dbuf[3], dbuf[2], dbuf[1], dbuf[0]} <= pwdata;
    end else if (d1_wr) begin
      {dbuf[7], dbuf[6], dbuf[5], dbuf[4]} <= pwdata;
    end
  end

  // link engine: start, nine-bit slots, stop, stepped by quarter ticks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ks <= K_IDLE;
      ph <= P_ADDRW;
      op <= ccfg_pkg::OP_BLK_WR;
      q <= 2'd0;
      bitn <= 4'd0;
      {txsh, rxsh} <= 18'd0;
      {idx, len, bidx} <= 13'd0;
      {busy, err, done} <= 3'b000;
      rcount <= 8'h00;
      {bus.scl_oe, bus.sda_ctl_oe} <= 2'b00;
    end else if (ctl_wr) begin
      op <= ccfg_pkg::ccfg_op_e'(pwdata[1:0]);
      idx <= pwdata[ccfg_pkg::CTRL_IDX_LSB +: 7];
      len <= pwdata[ccfg_pkg::CTRL_LEN_LSB +: 3];
      {busy, err, done} <= 3'b100;
      ks <= K_START;
      ph <= P_ADDRW;
      bidx <= 3'd0;
      q <= 2'd0;
    end else if (tick) begin
      q <= q + 2'd1;
      case (ks)
        K_START: begin
          case (q)
            2'd0: {bus.scl_oe, bus.sda_ctl_oe} <= 2'b10;
            2'd1: bus.scl_oe <= 1'b0;
            2'd2: bus.sda_ctl_oe <= 1'b1;
            default: begin
              bus.scl_oe <= 1'b1;
              ks <= K_BIT;
              bitn <= 4'd0;
              txsh <= slot;
            end
          endcase
        end
        K_BIT: begin
          case (q)
            2'd0: begin
              // load here: phase and index have moved on since the slot end
              if (bitn == 4'd0) begin
                txsh <= slot;
              end
              bus.sda_ctl_oe <= (bitn == 4'd0) ? !slot[8] : !txsh[8];
            end
            2'd1: bus.scl_oe <= 1'b0;
            2'd2: rxsh <= {rxsh[7:0], sda_s2};
            default: begin
              bus.scl_oe <= 1'b1;
              txsh <= {txsh[7:0], 1'b1};
              bitn <= bitn + 4'd1;
              if (bitn == 4'd8) begin
                bitn <= 4'd0;
                case (ph)
                  P_ADDRW: if (nack) {err, ks} <= {1'b1, K_STOP}; else ph <= P_CMD;
                  P_CMD: begin
                    if (nack) {err, ks} <= {1'b1, K_STOP};
                    else if (rdop) {ph, ks} <= {P_ADDRR, K_START};
                    else ph <= blk ? P_CNT : P_WDAT;
                  end
                  P_CNT: if (nack) {err, ks} <= {1'b1, K_STOP}; else ph <= P_WDAT;
                  P_WDAT: begin
                    bidx <= bidx + 3'd1;
                    if (nack) {err, ks} <= {1'b1, K_STOP};
                    else if (last) ks <= K_STOP;
                  end
                  P_ADDRR: if (nack) {err, ks} <= {1'b1, K_STOP};
                    else ph <= blk ? P_RCNT : P_RDAT;
                  P_RCNT: {rcount, ph} <= {rxsh[8:1], P_RDAT};
                  default: begin
                    bidx <= bidx + 3'd1;
                    if (last) ks <= K_STOP;
                  end
                endcase
              end
            end
          endcase
        end
        K_STOP: begin
          case (q)
            2'd0: bus.sda_ctl_oe <= 1'b1;
            2'd1: bus.scl_oe <= 1'b0;
            2'd2: bus.sda_ctl_oe <= 1'b0;
            default: {ks, busy, done} <= {K_IDLE, 2'b01};
          endcase
        end
        default: q <= 2'd0;
      endcase
    end
  end
endmodule : ccfg_ctrl
`default_nettype wire

// ===== hdl/ccfg_glitch_free_enable.sv
/*
  applies output enables only while the gated clock is low.
  assumes the synthesiser clocks arrive asynchronously to pclk.
*/
`timescale 1ns/1ps
`default_nettype none
module ccfg_glitch_free_enable #(
  parameter int W = 4
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // synthesiser clock levels and requested enables
  input wire logic [W-1:0] synth_clk,
  input wire logic [W-1:0] req,
  // applied enables
  output logic [W-1:0] en
);
  logic [W-1:0] clk_s1; // first stage, read only by clk_s2
  logic [W-1:0] clk_s2; // settled clock level

  // synchronise the clock levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s1 <= '0;
      clk_s2 <= '0;
    end else begin
      clk_s1 <= synth_clk;
      clk_s2 <= clk_s1;
    end
  end

  // change an enable only in the low half so no runt pulse appears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en <= '1;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (!clk_s2[i]) begin
          en[i] <= req[i];
        end
      end
    end
  end
endmodule : ccfg_glitch_free_enable
`default_nettype wire

// ===== hdl/ccfg_if.sv
/*
  two-wire link between controller and target.
  assumes pull-ups: a line is low only while some end enables a low drive.
*/
`timescale 1ns/1ps
`default_nettype none
interface ccfg_if;
  // clock line driver, controller only
  logic scl_o;
  logic scl_oe;
  // data line drivers of each end
  logic sda_ctl_o;
  logic sda_ctl_oe;
  logic sda_tgt_o;
  logic sda_tgt_oe;
  // resolved line levels
  wire logic scl_line;
  wire logic serial_bus_data_pin;
  assign scl_line = !(scl_oe && !scl_o);
  assign serial_bus_data_pin = !((sda_ctl_oe && !sda_ctl_o) || (sda_tgt_oe && !sda_tgt_o));
  modport target (input scl_line, input serial_bus_data_pin,
    output sda_tgt_o, output sda_tgt_oe);
  modport ctrl (input scl_line, input serial_bus_data_pin,
    output scl_o, output scl_oe, output sda_ctl_o, output sda_ctl_oe);
endinterface : ccfg_if
`default_nettype wire

// ===== hdl/ccfg_pkg.sv
/*
  shared constants for the configuration target and its bus controller.
  assumes a single 40 MHz pclk on both ends.
*/
package ccfg_pkg;
  // target address, 7 bits; with the direction bit it reads 8'hD2 / 8'hD3
  localparam logic [6:0] TGT_ADDR = 7'h69;
  // number of implemented register bytes, returned as the block count
  localparam int NUM_BYTES = 8;
  localparam logic [7:0] BYTE_COUNT = 8'h08;
  // byte indices and field positions
  localparam int IDX_OE = 0;
  localparam int IDX_SS = 2;
  localparam int IDX_T6 = 6;
  localparam int IDX_ID = 7;
  localparam int OE_LSB = 3;
  localparam int SS_EN_BIT = 2;
  localparam int SS_SEL_BIT = 7;
  localparam int CMD_SINGLE_BIT = 7;
  // power-up values of the register bytes
  localparam logic [7:0] RST_B0 = 8'h7C;
  localparam logic [7:0] RST_B2 = 8'hEA;
  localparam logic [7:0] RST_B6 = 8'h13;
  localparam logic [7:0] RST_ZERO = 8'h00;
  // writable bits; reserved bits keep their power-up value
  localparam logic [7:0] WMASK_B0 = 8'h78;
  localparam logic [7:0] WMASK_B2 = 8'h84;
  // controller apb map
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STAT = 8'h04;
  localparam logic [7:0] OFF_DATA0 = 8'h08;
  localparam logic [7:0] OFF_DATA1 = 8'h0C;
  // ctrl fields: op [1:0], index [14:8], block length minus one [18:16]
  localparam int CTRL_IDX_LSB = 8;
  localparam int CTRL_LEN_LSB = 16;
  // controller bit timing: one quarter of a serial clock period
  localparam int CLK_NS = 25;
  localparam int QTR_NS = 125;
  localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
  // controller operations
  typedef enum logic [1:0] {
    OP_BLK_WR = 2'b00,
    OP_BLK_RD = 2'b01,
    OP_ONE_WR = 2'b10,
    OP_ONE_RD = 2'b11
  } ccfg_op_e;
endpackage : ccfg_pkg

// ===== hdl/ccfg_target.sv
/*
  two-wire configuration target: eight register bytes, byte and block
  access, output enables and spread selection.
  assumes the controller makes the serial clock; both lines are sampled
  by pclk through two flip-flops.
*/
// Function
// - output enables switch without glitches
// - spread off, shallow or deep selectable
// - registers take defaults at reset
// - byte and block, read and write
// - block bytes ascend, msb first
// - block may end after any byte
// - command top bit: one single, zero block
// - low seven bits index single access
// - full seven-bit index used, not two bits
// - answer only address 8'hD2 / 8'hD3
// - block write: address, command, count, data
// - block write data starts at byte zero
// - block read: count then data bytes
// - controller nacks last byte then stops
// - single write stores one indexed byte
// - single read returns one indexed byte
// - byte zero bits six..three enable outputs
// - byte two bit two enables spread
// - byte two bit seven selects depth
`timescale 1ns/1ps
`default_nettype none
module ccfg_target #(
  parameter logic [7:0] IDENT = 8'h5A // identity byte, value arbitrary
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // serial link
  ccfg_if.target bus,
  // synthesiser clock levels, one per output
  input wire logic [3:0] synth_clk,
  // configuration to the synthesiser
  output logic output0_enable,
  output logic output1_enable,
  output logic output2_enable,
  output logic output3_enable,
  output logic spread_enable,
  output logic spread_deep
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_RX = 3'b011,
    ST_TX = 3'b100,
    ST_MACK = 3'b101,
    ST_IGNORE = 3'b110
  } ccfg_state_e;
  typedef enum logic [1:0] {
    PH_CMD = 2'b00,
    PH_CNT = 2'b01,
    PH_DATA = 2'b10
  } ccfg_phase_e;

  logic scl_s1, scl_s2, scl_s3; // clock sync and history
  logic sda_s1, sda_s2, sda_s3; // data sync and history
  ccfg_state_e state;
  ccfg_phase_e phase; // what the next written byte means
  logic [3:0] bitcnt; // bits moved in this byte
  logic [7:0] shreg; // shift register, both directions
  logic [6:0] ptr; // register byte pointer
  logic blk; // block operation in progress
  logic rd; // read direction of current address
  logic cnt_pending; // block read still owes the count byte
  logic mack; // controller acknowledge sampled
  localparam int NUM_BYTES = ccfg_pkg::NUM_BYTES;
  logic [7:0] regs [NUM_BYTES]; // register bytes
  logic [3:0] oe_en; // enables after glitch-free gating

  // power-up value of a byte
  function automatic logic [7:0] rst_val(input int i);
    case (i)
      ccfg_pkg::IDX_OE: rst_val = ccfg_pkg::RST_B0;
      ccfg_pkg::IDX_SS: rst_val = ccfg_pkg::RST_B2;
      ccfg_pkg::IDX_T6: rst_val = ccfg_pkg::RST_B6;
      default: rst_val = ccfg_pkg::RST_ZERO;
    endcase
  endfunction : rst_val

  // writable bits of a byte
  function automatic logic [7:0] wmask(input logic [6:0] i);
    case (i)
      7'h00: wmask = ccfg_pkg::WMASK_B0;
      7'h02: wmask = ccfg_pkg::WMASK_B2;
      default: wmask = 8'h00;
    endcase
  endfunction : wmask

  // line events, seen on the settled samples only
  wire scl_rise = scl_s2 && !scl_s3;
  wire scl_fall = !scl_s2 && scl_s3;
  wire start_det = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  wire stop_det = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  wire ptr_ok = ptr < 7'(NUM_BYTES);
  // out-of-range index reads zero, writes are dropped
  wire [7:0] rd_byte = ptr_ok ? regs[ptr[2:0]] : 8'h00;
  wire [7:0] id_byte = IDENT;
  wire [7:0] tx_byte = cnt_pending ? ccfg_pkg::BYTE_COUNT : rd_byte;
  wire addr_hit = shreg[7:1] == ccfg_pkg::TGT_ADDR;
  wire wr_data = (state == ST_RX) && scl_fall && (bitcnt == 4'd8) && (phase == PH_DATA);

  // open drain: only ever drive low
  assign bus.sda_tgt_o = 1'b0;

  // two-flop synchronisers plus one history stage for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {scl_s1, scl_s2, scl_s3} <= 3'b111;
      {sda_s1, sda_s2, sda_s3} <= 3'b111;
    end else begin
      scl_s1 <= bus.scl_line;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= bus.serial_bus_data_pin;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  // protocol engine: sample on rising clock, drive after falling clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      phase <= PH_CMD;
      bitcnt <= 4'd0;
      shreg <= 8'h00;
      ptr <= 7'd0;
      blk <= 1'b0;
      rd <= 1'b0;
      cnt_pending <= 1'b0;
      mack <= 1'b0;
      bus.sda_tgt_oe <= 1'b0;
    end else if (start_det) begin
      // start or repeated start; pointer and mode survive a restart
      state <= ST_ADDR;
      bitcnt <= 4'd0;
      bus.sda_tgt_oe <= 1'b0;
    end else if (stop_det) begin
      // stop ends any transfer at a byte boundary or not
      state <= ST_IDLE;
      bus.sda_tgt_oe <= 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_RX: begin
          if (scl_rise && bitcnt != 4'd8) begin
            shreg <= {shreg[6:0], sda_s2};
            bitcnt <= bitcnt + 4'd1;
          end else if (scl_fall && bitcnt == 4'd8) begin
            if (state == ST_ADDR) begin
              if (addr_hit) begin
                rd <= shreg[0];
                state <= ST_ACK;
                bus.sda_tgt_oe <= 1'b1;
                if (!shreg[0]) begin
                  phase <= PH_CMD;
                end
                cnt_pending <= shreg[0] && blk;
              end else begin
                state <= ST_IGNORE;
              end
            end else begin
              state <= ST_ACK;
              bus.sda_tgt_oe <= 1'b1;
              case (phase)
                PH_CMD: begin
                  blk <= !shreg[ccfg_pkg::CMD_SINGLE_BIT];
                  // block starts at byte zero, single uses the index
                  ptr <= shreg[ccfg_pkg::CMD_SINGLE_BIT] ? shreg[6:0] : 7'd0;
                  phase <= shreg[ccfg_pkg::CMD_SINGLE_BIT] ? PH_DATA : PH_CNT;
                end
                PH_CNT: phase <= PH_DATA;
                default: ptr <= ptr + 7'd1;
              endcase
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bitcnt <= 4'd0;
            if (rd) begin
              // first read bit goes out as the ack is released
              state <= ST_TX;
              shreg <= {tx_byte[6:0], 1'b0};
              bus.sda_tgt_oe <= !tx_byte[7];
              bitcnt <= 4'd1;
              cnt_pending <= 1'b0;
              if (!cnt_pending) begin
                ptr <= ptr + 7'd1;
              end
            end else begin
              state <= ST_RX;
              bus.sda_tgt_oe <= 1'b0;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bitcnt == 4'd8) begin
              bus.sda_tgt_oe <= 1'b0;
              state <= ST_MACK;
            end else begin
              bus.sda_tgt_oe <= !shreg[7];
              shreg <= {shreg[6:0], 1'b0};
              bitcnt <= bitcnt + 4'd1;
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            mack <= !sda_s2;
          end else if (scl_fall) begin
            if (mack) begin
              // next byte in ascending order
              state <= ST_TX;
              shreg <= {rd_byte[6:0], 1'b0};
              bus.sda_tgt_oe <= !rd_byte[7];
              bitcnt <= 4'd1;
              ptr <= ptr + 7'd1;
            end else begin
              state <= ST_IGNORE;
            end
          end
        end
        ST_IGNORE: bus.sda_tgt_oe <= 1'b0;
        default: state <= ST_IDLE;
      endcase
    end
  end

  // register bytes; a completed data byte is stored at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NUM_BYTES; i++) begin
        regs[i] <= rst_val(i);
      end
    end else begin
      regs[ccfg_pkg::IDX_ID] <= id_byte;
      if (wr_data && ptr_ok) begin
        // reserved bits hold their value
        regs[ptr[2:0]] <= (regs[ptr[2:0]] & ~wmask(ptr)) | (shreg & wmask(ptr));
      end
    end
  end

  // enable gating so a switch never cuts a clock pulse short
  ccfg_glitch_free_enable #(
    .W(4)
  ) u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .synth_clk(synth_clk),
    .req(regs[ccfg_pkg::IDX_OE][ccfg_pkg::OE_LSB +: 4]),
    .en(oe_en)
  );

  // registered configuration outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {output3_enable, output2_enable, output1_enable, output0_enable} <= 4'hF;
      spread_enable <= 1'b0;
      spread_deep <= 1'b1;
    end else begin
      {output3_enable, output2_enable, output1_enable, output0_enable} <= oe_en;
      spread_enable <= regs[ccfg_pkg::IDX_SS][ccfg_pkg::SS_EN_BIT];
      spread_deep <= regs[ccfg_pkg::IDX_SS][ccfg_pkg::SS_SEL_BIT];
    end
  end
endmodule : ccfg_target
`default_nettype wire

// ===== test/ccfg_link_props.sv
/*
  link checker: watches the drivers and the resolved lines of the link.
  assumes one pclk for both ends and the pull-ups of the interface.
*/
`timescale 1ns/1ps
`default_nettype none
module ccfg_link_props (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // drivers of both ends
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_ctl_o,
  input wire logic sda_ctl_oe,
  input wire logic sda_tgt_o,
  input wire logic sda_tgt_oe,
  // resolved lines
  input wire logic scl_line,
  input wire logic serial_bus_data_pin
);
  // one domain, so clock and reset are given once
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_quiet_after_reset: assert property ($rose(presetn) |-> !sda_tgt_oe && !scl_oe && !sda_ctl_oe)
    else $error("link driven right after reset");
  chk_tgt_pull_low: assert property (sda_tgt_oe |-> !sda_tgt_o)
    else $error("target drives data high");
  chk_ctl_pull_low: assert property (!(scl_oe && scl_o) && !(sda_ctl_oe && sda_ctl_o))
    else $error("controller drives a line high");
  chk_tgt_moves_low: assert property ($changed(sda_tgt_oe) |-> !scl_line)
    else $error("target changed data while clock high");
  // start and stop belong to the controller alone
  chk_tgt_no_framing: assert property (scl_line && $past(scl_line)
    && $changed(serial_bus_data_pin) |-> !sda_tgt_oe && !$past(sda_tgt_oe))
    else $error("target made a start or stop");
  chk_scl_high_width: assert property ($rose(scl_line) |-> scl_line [*4])
    else $error("clock high phase too short");
  chk_scl_low_width: assert property ($fell(scl_line) |-> !scl_line [*4])
    else $error("clock low phase too short");
  chk_scl_low_bound: assert property (!scl_line |-> ##[1:40] scl_line)
    else $error("clock held low too long");
  // main scenarios seen on the wire
  cv_tgt_ack: cover property ($rose(sda_tgt_oe));
  cv_start: cover property (scl_line && $fell(serial_bus_data_pin));
  cv_stop: cover property (scl_line && $rose(serial_bus_data_pin));
endmodule : ccfg_link_props
`default_nettype wire

// ===== test/testbench.sv
/*
  testbench: controller and target joined by the link, driven over apb.
  assumes the package constants and one pclk for both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // clock, reset and apb drive
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, err_seen;
  // synthesiser clocks: each bit at half the rate of the one below
  logic [3:0] synth_clk = 4'h0;
  logic output0_enable, output1_enable, output2_enable, output3_enable;
  logic spread_enable, spread_deep;
  wire logic [5:0] outs;
  int n_mismatch = 0;
  int n_compared = 0;
  assign outs = {output3_enable, output2_enable, output1_enable, output0_enable,
    spread_enable, spread_deep};
  ccfg_if ccfg_if_i ();
  ccfg_target ccfg_target_i (.pclk(pclk), .presetn(presetn), .bus(ccfg_if_i),
    .synth_clk(synth_clk), .output0_enable(output0_enable), .output1_enable(output1_enable),
    .output2_enable(output2_enable), .output3_enable(output3_enable),
    .spread_enable(spread_enable), .spread_deep(spread_deep));
  ccfg_ctrl ccfg_ctrl_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(ccfg_if_i));
  ccfg_link_props ccfg_link_props_i (.pclk(pclk), .presetn(presetn),
    .scl_o(ccfg_if_i.scl_o), .scl_oe(ccfg_if_i.scl_oe), .sda_ctl_o(ccfg_if_i.sda_ctl_o),
    .sda_ctl_oe(ccfg_if_i.sda_ctl_oe), .sda_tgt_o(ccfg_if_i.sda_tgt_o),
    .sda_tgt_oe(ccfg_if_i.sda_tgt_oe), .scl_line(ccfg_if_i.scl_line),
    .serial_bus_data_pin(ccfg_if_i.serial_bus_data_pin));
  // 40 MHz clock
  always #12.5 pclk = ~pclk;
  // free-running synthesiser levels, so the enable gating can act
  always @(posedge pclk) begin
    synth_clk <= synth_clk + 4'h1;
  end
  // one apb transfer; entered right after an edge, leaves one edge after release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  // start one link operation and poll status until it is no longer busy
  task automatic go(input ccfg_pkg::ccfg_op_e op, input logic [6:0] ix,
    input logic [2:0] ln, output logic [31:0] q);
    int n;
    n = 0;
    apb(1'b1, ccfg_pkg::OFF_CTRL, {13'h0, ln, 1'b0, ix, 6'h0, op}, q);
    do begin
      apb(1'b0, ccfg_pkg::OFF_STAT, 32'h0000_0000, q);
      n++;
    end while (q[0] !== 1'b0 && n < 2000);
    chk("stat_flags", 32'h0000_0004, {29'h0, q[2:0]});
  endtask : go
  task automatic t_spread();
    logic [31:0] q;
    logic [7:0] v [3] = '{8'h00, 8'h04, 8'h84};
    foreach (v[i]) begin
      apb(1'b1, ccfg_pkg::OFF_DATA0, {24'h0, v[i]}, q);
      go(ccfg_pkg::OP_ONE_WR, 7'h02, 3'h0, q);
      chk("spread", {30'h0, v[i][2], v[i][7]}, {30'h0, outs[1:0]});
    end
  endtask : t_spread
  task automatic t_byte_rw();
    logic [31:0] q;
    apb(1'b1, ccfg_pkg::OFF_DATA0, 32'h0000_0000, q);
    go(ccfg_pkg::OP_ONE_WR, 7'h00, 3'h0, q);
    // gating waits for each synthesiser clock to be low
    repeat (24) @(posedge pclk);
    chk("outs_off", 32'h0000_0003, {26'h0, outs});
    go(ccfg_pkg::OP_ONE_RD, 7'h00, 3'h0, q);
    apb(1'b0, ccfg_pkg::OFF_DATA0, 32'h0000_0000, q);
    chk("byte0", 32'h0000_0004, {24'h0, q[7:0]});
    // index six needs more than the two low command bits
    go(ccfg_pkg::OP_ONE_RD, 7'h06, 3'h0, q);
    apb(1'b0, ccfg_pkg::OFF_DATA0, 32'h0000_0000, q);
    chk("byte6", 32'h0000_0013, {24'h0, q[7:0]});
  endtask : t_byte_rw
  task automatic t_block_wr();
    logic [31:0] q;
    apb(1'b1, ccfg_pkg::OFF_DATA0, 32'h0004_FF48, q);
    go(ccfg_pkg::OP_BLK_WR, 7'h00, 3'h2, q);
    repeat (24) @(posedge pclk);
    chk("outs_block", 32'h0000_0026, {26'h0, outs});
  endtask : t_block_wr
  task automatic t_block_rd();
    logic [31:0] q;
    go(ccfg_pkg::OP_BLK_RD, 7'h00, 3'h7, q);
    chk("count", 32'h0000_0008, {24'h0, q[15:8]});
    apb(1'b0, ccfg_pkg::OFF_DATA0, 32'h0000_0000, q);
    chk("data0", 32'h006E_004C, q);
    apb(1'b0, ccfg_pkg::OFF_DATA1, 32'h0000_0000, q);
    chk("data1", 32'h5A13_0000, q);
    // short read: stale ones must be replaced by the two bytes received
    apb(1'b1, ccfg_pkg::OFF_DATA0, 32'hFFFF_FFFF, q);
    go(ccfg_pkg::OP_BLK_RD, 7'h00, 3'h1, q);
    apb(1'b0, ccfg_pkg::OFF_DATA0, 32'h0000_0000, q);
    chk("short_read", 32'h0000_004C, {16'h0, q[15:0]});
  endtask : t_block_rd
  task automatic t_unmapped();
    logic [31:0] q;
    apb(1'b0, 8'h10, 32'h0000_0000, q);
    chk("slverr", 32'h0000_0001, {31'h0, err_seen});
    chk("unmapped_data", 32'h0000_0000, q);
  endtask : t_unmapped
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("outs_reset", 32'h0000_003D, {26'h0, outs});
    t_spread();
    t_byte_rw();
    t_block_wr();
    t_block_rd();
    t_unmapped();
    close_out();
  end
  // watchdog: about five times the expected run
  initial begin
    #1_000_000;
    n_mismatch++;
    close_out();
  end
endmodule : testbench
`default_nettype wire
